// ===== core/uart_buf_pkg.sv
// constants, field layouts and carrier types of the serial port buffer block
// assumes the host bus, line control and status logic sit outside this block
package uart_buf_pkg;
  // register offsets on the host address lines
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_IER = 3'h1;
  localparam logic [2:0] OFS_IIR = 3'h2;
  // interrupt enable bit positions and width
  localparam int IER_RDA = 0;
  localparam int IER_THRE = 1;
  localparam int IER_LSI = 2;
  localparam int IER_MSI = 3;
  localparam int IER_WIDTH = 4;
  // identification codes, bits 3:0, and fifo enabled values, bits 7:6
  localparam logic [3:0] IIR_NONE = 4'h1;
  localparam logic [3:0] IIR_LSI = 4'h6;
  localparam logic [3:0] IIR_RDA = 4'h4;
  localparam logic [3:0] IIR_TOUT = 4'hc;
  localparam logic [3:0] IIR_THRE = 4'h2;
  localparam logic [3:0] IIR_MSI = 4'h0;
  localparam logic [1:0] IIR_FIFO_ON = 2'h3;
  localparam logic [1:0] IIR_FIFO_OFF = 2'h0;
  // character format and time-out
  localparam int DATA_BITS = 8;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] TOUT_CHARS = 3'h4;
  // trigger levels in bytes for encodings 0..3
  localparam int TRIG_L0 = 1;
  localparam int TRIG_L1 = 4;
  localparam int TRIG_L2 = 8;
  localparam int TRIG_L3 = 14;

  typedef struct packed {
    logic [2:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } host_req_type;

  typedef struct packed {
    logic divisor_latch_access;
    logic fifo_enable;
    logic [1:0] rx_trigger;
    logic irq_output_gate;
  } port_ctrl_type;

  typedef struct packed {
    logic line_status_set;
    logic line_status_read;
    logic modem_change;
    logic modem_status_read;
  } status_event_type;

  // trigger encoding to byte count
  function automatic int trigger_level(input logic [1:0] code);
    case (code)
      2'h0: trigger_level = TRIG_L0;
      2'h1: trigger_level = TRIG_L1;
      2'h2: trigger_level = TRIG_L2;
      default: trigger_level = TRIG_L3;
    endcase
  endfunction : trigger_level
endpackage : uart_buf_pkg

// ===== core/rx_fifo.sv
// receive fifo with valid and ready on both sides and a fill count
// assumes a single clock; flush empties it in one cycle
`timescale 1ns/1ps
module rx_fifo
  import uart_buf_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
)(
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic flush_in,
  // fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out,
  output logic [$clog2(DEPTH+1)-1:0] count_out
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  initial if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("depth must be a power of two");

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] count;
  } fifo_state_type;

  fifo_state_type state_ff;
  fifo_state_type nxt_state;
  logic push;
  logic pop;

  // handshakes and head word
  assign in_ready_out = (state_ff.count != CW'(DEPTH));
  assign out_valid_out = (state_ff.count != '0);
  assign out_data_out = state_ff.mem[state_ff.rd_ptr];
  assign count_out = state_ff.count;
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  // pointer and count update
  always_comb
  begin
    nxt_state = state_ff;
    if (push)
    begin
      nxt_state.mem[state_ff.wr_ptr] = in_data_in;
      nxt_state.wr_ptr = state_ff.wr_ptr + AW'(1);
    end
    if (pop)
      nxt_state.rd_ptr = state_ff.rd_ptr + AW'(1);
    nxt_state.count = state_ff.count + CW'(push) - CW'(pop);
    if (flush_in)
    begin
      nxt_state.wr_ptr = '0;
      nxt_state.rd_ptr = '0;
      nxt_state.count = '0;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in)
    if (!reset_n_in)
      state_ff <= '0;
    else
      state_ff <= nxt_state;
endmodule : rx_fifo

// ===== core/uart_buffers.sv
// receive and transmit buffers, interrupt enables and prioritised identification
// assumes line control, fifo control, status and baud logic sit outside and
// deliver one bit_tick_in pulse per bit time and one char_tick_in per character time
// Operation
// - offset 0 read returns received character
// - characters go least significant bit first
// - hidden shift register assembles received bytes
// - offset 0 write loads transmit holding
// - transmit shifter loads after previous byte
// - enable register low four bits
// - no enables means no interrupt shown
// - bit 0 enables data and time-out
// - bit 1 enables holding-empty interrupt
// - bit 2 enables line status interrupt
// - bit 3 enables modem status interrupt
// - reserved bits read zero, ignore writes
// - offset 2 reports highest priority pending
// - report frozen during identification read
// - bit 0 low when interrupt pending
// - identification codes per source
// - time-out bit only in fifo mode
// - bits 7:6 mirror fifo enable
// - data interrupt clears on read/below trigger
// - time-out after four idle character times
// - holding-empty clears on report read/write
// - interrupt driven only when gate set
// - divisor access bit remaps offsets 0,1
`timescale 1ns/1ps
module uart_buffers
  import uart_buf_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
)(
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // host register access
  input wire host_req_type host_in,
  output logic [7:0] rdata_out,
  // control from neighbouring registers
  input wire port_ctrl_type ctrl_in,
  input wire status_event_type events_in,
  // timing strobes
  input wire logic bit_tick_in,
  input wire logic char_tick_in,
  // serial line
  input wire logic rx_serial_in,
  output logic tx_serial_out,
  // interrupt pin, tri-state
  output logic irq_out,
  output logic irq_oe_out,
  // status for the line status logic
  output logic rx_data_ready_out,
  output logic tx_idle_out
);
  initial if (FIFO_DEPTH < 2) $error("fifo depth too small");
  localparam int CW = $clog2(FIFO_DEPTH+1);

  typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_STOP, RX_DONE} rx_state_type;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_type;

  typedef struct packed {
    rx_state_type rx_state;
    logic [2:0] rx_bit;
    logic [7:0] rx_shift;
    tx_state_type tx_state;
    logic [2:0] tx_bit;
    logic [7:0] tx_shift;
    logic tx_line;
    logic [7:0] thr;
    logic thr_full;
    logic [IER_WIDTH-1:0] interrupt_enable;
    logic lsi_pend;
    logic thre_pend;
    logic msi_pend;
    logic tout_pend;
    logic [2:0] idle_chars;
    logic fifo_en_prev;
    logic rd_prev;
    logic [7:0] rdata;
  } state_type;

  state_type state_ff;
  state_type nxt_state;

  logic fifo_in_ready;
  logic fifo_valid;
  logic fifo_pop;
  logic fifo_push;
  logic fifo_flush;
  logic [7:0] fifo_head;
  logic [CW-1:0] fifo_count;
  logic rd_start;
  logic rx_ready;
  logic rda_level;
  logic [3:0] iir_code;
  logic [7:0] iir_value;
  logic [IER_WIDTH-1:0] pend_en;

  // access decode
  assign rd_start = host_in.rd && !state_ff.rd_prev;
  assign fifo_pop = rd_start && host_in.addr == OFS_DATA
    && !ctrl_in.divisor_latch_access;
  assign fifo_flush = ctrl_in.fifo_enable != state_ff.fifo_en_prev;
  // outside fifo mode the buffer holds a single character
  assign rx_ready = fifo_in_ready && (ctrl_in.fifo_enable || !fifo_valid);
  assign fifo_push = state_ff.rx_state == RX_DONE && rx_ready;

  rx_fifo #(
    .WIDTH(DATA_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .flush_in(fifo_flush),
    .in_valid_in(fifo_push),
    .in_ready_out(fifo_in_ready),
    .in_data_in(state_ff.rx_shift),
    .out_valid_out(fifo_valid),
    .out_ready_in(fifo_pop),
    .out_data_out(fifo_head),
    .count_out(fifo_count)
  );

  // received data level, trigger clamped to the fifo depth
  always_comb
  begin
    int trig;
    trig = trigger_level(ctrl_in.rx_trigger);
    if (trig > FIFO_DEPTH)
      trig = FIFO_DEPTH;
    if (ctrl_in.fifo_enable)
      rda_level = int'(fifo_count) >= trig;
    else
      rda_level = fifo_valid;
  end

  // enabled pending sources and identification
  assign pend_en[IER_LSI] = state_ff.interrupt_enable[IER_LSI] && state_ff.lsi_pend;
  assign pend_en[IER_RDA] = state_ff.interrupt_enable[IER_RDA]
    && (rda_level || (state_ff.tout_pend && ctrl_in.fifo_enable));
  assign pend_en[IER_THRE] = state_ff.interrupt_enable[IER_THRE] && state_ff.thre_pend;
  assign pend_en[IER_MSI] = state_ff.interrupt_enable[IER_MSI] && state_ff.msi_pend;

  always_comb
  begin
    if (pend_en[IER_LSI])
      iir_code = IIR_LSI;
    else if (pend_en[IER_RDA])
      iir_code = rda_level ? IIR_RDA : IIR_TOUT;
    else if (pend_en[IER_THRE])
      iir_code = IIR_THRE;
    else if (pend_en[IER_MSI])
      iir_code = IIR_MSI;
    else
      iir_code = IIR_NONE;
  end
  // bits 5:4 reserved as zero
  assign iir_value = {ctrl_in.fifo_enable ? IIR_FIFO_ON : IIR_FIFO_OFF,
    2'h0, iir_code};

  // next state of buffers, shifters and interrupt flags
  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.rd_prev = host_in.rd;
    nxt_state.fifo_en_prev = ctrl_in.fifo_enable;
    // receiver: start bit, eight data bits lsb first, stop bit
    case (state_ff.rx_state)
      RX_IDLE:
        if (bit_tick_in && !rx_serial_in)
        begin
          nxt_state.rx_state = RX_DATA;
          nxt_state.rx_bit = '0;
        end
      RX_DATA:
        if (bit_tick_in)
        begin
          nxt_state.rx_shift = {rx_serial_in, state_ff.rx_shift[7:1]};
          nxt_state.rx_bit = state_ff.rx_bit + 3'h1;
          if (state_ff.rx_bit == LAST_BIT)
            nxt_state.rx_state = RX_STOP;
        end
      RX_STOP:
        if (bit_tick_in)
          nxt_state.rx_state = RX_DONE;
      RX_DONE:
        if (rx_ready)
          nxt_state.rx_state = RX_IDLE; // stalls while buffer full
      default:
        nxt_state.rx_state = RX_IDLE;
    endcase
    // transmitter
    case (state_ff.tx_state)
      TX_IDLE:
        if (state_ff.thr_full)
        begin
          nxt_state.tx_shift = state_ff.thr;
          nxt_state.thr_full = 1'b0;
          nxt_state.thre_pend = 1'b1;
          nxt_state.tx_state = TX_START;
        end
      TX_START:
        if (bit_tick_in)
        begin
          nxt_state.tx_line = 1'b0;
          nxt_state.tx_bit = '0;
          nxt_state.tx_state = TX_DATA;
        end
      TX_DATA:
        if (bit_tick_in)
        begin
          nxt_state.tx_line = state_ff.tx_shift[0];
          nxt_state.tx_shift = {1'b0, state_ff.tx_shift[7:1]};
          nxt_state.tx_bit = state_ff.tx_bit + 3'h1;
          if (state_ff.tx_bit == LAST_BIT)
            nxt_state.tx_state = TX_STOP;
        end
      TX_STOP:
        if (bit_tick_in)
        begin
          nxt_state.tx_line = 1'b1;
          nxt_state.tx_state = TX_IDLE;
        end
      default:
        nxt_state.tx_state = TX_IDLE;
    endcase
    // host reads: data captured at access start and held, freezing the report
    if (rd_start)
    begin
      case (host_in.addr)
        OFS_DATA:
          nxt_state.rdata = ctrl_in.divisor_latch_access ? 8'h00 : fifo_head;
        OFS_IER:
          nxt_state.rdata = ctrl_in.divisor_latch_access ? 8'h00
            : {4'h0, state_ff.interrupt_enable};
        OFS_IIR:
        begin
          nxt_state.rdata = iir_value;
          if (iir_code == IIR_THRE)
            nxt_state.thre_pend = 1'b0;
        end
        default:
          nxt_state.rdata = 8'h00;
      endcase
    end
    // host writes
    if (host_in.wr && !ctrl_in.divisor_latch_access)
    begin
      if (host_in.addr == OFS_DATA)
      begin
        nxt_state.thr = host_in.wdata;
        nxt_state.thr_full = 1'b1;
        nxt_state.thre_pend = 1'b0;
      end
      if (host_in.addr == OFS_IER)
        nxt_state.interrupt_enable = host_in.wdata[IER_WIDTH-1:0];
    end
    // line and modem status flags: set wins over clear
    if (events_in.line_status_read)
      nxt_state.lsi_pend = 1'b0;
    if (events_in.line_status_set)
      nxt_state.lsi_pend = 1'b1;
    if (events_in.modem_status_read)
      nxt_state.msi_pend = 1'b0;
    if (events_in.modem_change)
      nxt_state.msi_pend = 1'b1;
    // character time-out: idle character times counted while data waits
    if (fifo_push || fifo_pop || !fifo_valid || !ctrl_in.fifo_enable)
    begin
      nxt_state.idle_chars = '0;
      nxt_state.tout_pend = 1'b0;
    end
    else if (char_tick_in && state_ff.idle_chars != TOUT_CHARS)
      nxt_state.idle_chars = state_ff.idle_chars + 3'h1;
    if (state_ff.idle_chars == TOUT_CHARS && fifo_valid && ctrl_in.fifo_enable
        && !fifo_pop && !fifo_push)
      nxt_state.tout_pend = 1'b1;
  end

  always_ff @(posedge clock_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      state_ff <= '0;
      state_ff.rx_state <= RX_IDLE;
      state_ff.tx_state <= TX_IDLE;
      state_ff.tx_line <= 1'b1;
      state_ff.thre_pend <= 1'b1;
    end
    else
      state_ff <= nxt_state;

  // outputs
  assign rdata_out = state_ff.rdata;
  assign tx_serial_out = state_ff.tx_line;
  assign irq_out = |pend_en;
  assign irq_oe_out = ctrl_in.irq_output_gate;
  assign rx_data_ready_out = fifo_valid;
  assign tx_idle_out = state_ff.tx_state == TX_IDLE && !state_ff.thr_full;

  // checks
  chk_iir_none: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    rd_start && host_in.addr == OFS_IIR && state_ff.interrupt_enable == '0
    |=> rdata_out[3:0] == IIR_NONE && !irq_out)
    else $error("identification not none with all enables clear");
  chk_irq_gate: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    irq_oe_out == ctrl_in.irq_output_gate && (irq_out == (pend_en != '0)))
    else $error("interrupt pin drive wrong");
  chk_lsi_first: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    rd_start && host_in.addr == OFS_IIR && state_ff.lsi_pend && state_ff.interrupt_enable[IER_LSI]
    |=> rdata_out == {ctrl_in.fifo_enable ? IIR_FIFO_ON : IIR_FIFO_OFF, 2'h0, IIR_LSI})
    else $error("line status not reported first");
  chk_thr_write: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    host_in.wr && host_in.addr == OFS_DATA && !ctrl_in.divisor_latch_access
    |=> !state_ff.thre_pend && state_ff.thr == $past(host_in.wdata))
    else $error("holding write did not clear empty interrupt");
  chk_iir_freeze: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    host_in.rd && state_ff.rd_prev |=> $stable(rdata_out))
    else $error("report changed during read");
  chk_fifo_bits: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    rd_start && host_in.addr == OFS_IIR
    |=> rdata_out[7:6] == {2{$past(ctrl_in.fifo_enable)}})
    else $error("fifo enabled bits wrong");
  chk_tout_mode: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    rd_start && host_in.addr == OFS_IIR && !ctrl_in.fifo_enable
    |=> rdata_out[3] == 1'b0 && rdata_out[5:4] == 2'h0)
    else $error("time-out bit set outside fifo mode");
  chk_ier_read: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    rd_start && host_in.addr == OFS_IER && !ctrl_in.divisor_latch_access
    |=> rdata_out == {4'h0, $past(state_ff.interrupt_enable)})
    else $error("enable register read wrong");
  chk_tout_cause: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    $rose(state_ff.tout_pend) |-> $past(state_ff.idle_chars) == TOUT_CHARS
      && ctrl_in.fifo_enable)
    else $error("time-out without four idle characters");
  chk_thre_iir: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    rd_start && host_in.addr == OFS_IIR && iir_code == IIR_THRE
    && !(state_ff.tx_state == TX_IDLE && state_ff.thr_full) |=> !state_ff.thre_pend)
    else $error("holding empty not cleared by report read");
  chk_ier_write: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    host_in.wr && host_in.addr == OFS_IER && !ctrl_in.divisor_latch_access
    |=> state_ff.interrupt_enable == $past(host_in.wdata[IER_WIDTH-1:0]))
    else $error("enable write lost");
  chk_lsi_set: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    events_in.line_status_set
    |=> state_ff.lsi_pend)
    else $error("line status event lost");
  chk_msi_clear: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    events_in.modem_status_read && !events_in.modem_change
    |=> !state_ff.msi_pend)
    else $error("modem interrupt not cleared");
  chk_rda_clear: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    fifo_pop && rx_data_ready_out && !ctrl_in.fifo_enable
    |=> !rx_data_ready_out)
    else $error("data interrupt not cleared");
  chk_tx_load: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    $changed(state_ff.tx_shift) && !$past(bit_tick_in)
    |-> $past(state_ff.tx_state) == TX_IDLE)
    else $error("shifter loaded during a byte");
  chk_tx_lsb: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    state_ff.tx_state == TX_DATA && bit_tick_in
    |=> tx_serial_out == $past(state_ff.tx_shift[0]))
    else $error("transmit bit order wrong");
  chk_tout_clear: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    fifo_pop && rx_data_ready_out
    |=> !state_ff.tout_pend)
    else $error("time-out not cleared");
endmodule : uart_buffers

// ===== dv/host_model.sv
// host processor model: register reads and writes, status register read pulses
// assumes one caller at a time and a free-running clock
`timescale 1ns/1ps
module host_model
  import uart_buf_pkg::*;
(
  // clock
  input wire logic clock_in,
  // register access
  output host_req_type host_out,
  input wire logic [7:0] rdata_in,
  // status register reads seen by neighbouring logic
  output logic line_read_out,
  output logic modem_read_out
);
  // bus idle from time zero
  initial
  begin
    host_out = '0;
    line_read_out = 1'b0;
    modem_read_out = 1'b0;
  end

  // one write, strobe high for a single clock
  task automatic reg_write(input logic [2:0] addr, input logic [7:0] data);
    @(negedge clock_in);
    host_out.addr = addr;
    host_out.wdata = data;
    host_out.wr = 1'b1;
    @(negedge clock_in);
    host_out.wr = 1'b0;
  endtask : reg_write

  // read held for the answer cycle plus extra hold cycles, low again afterwards
  task automatic reg_read(input logic [2:0] addr, input int hold, output logic [7:0] data);
    @(negedge clock_in);
    host_out.addr = addr;
    host_out.rd = 1'b1;
    repeat (2 + hold) @(posedge clock_in);
    @(negedge clock_in);
    data = rdata_in;
    host_out.rd = 1'b0;
  endtask : reg_read

  // status register read, one-cycle pulse; line status read clears its interrupt
  task automatic status_read(input logic modem);
    @(negedge clock_in);
    if (modem)
      modem_read_out = 1'b1;
    else
      line_read_out = 1'b1;
    @(negedge clock_in);
    modem_read_out = 1'b0;
    line_read_out = 1'b0;
  endtask : status_read
endmodule : host_model

// ===== dv/uart_buffers_tb.sv
// self-checking bench for the serial port buffers and interrupt identification
// assumes the host model drives the register bus; bench drives ticks and serial line
`timescale 1ns/1ps
module uart_buffers_tb
  import uart_buf_pkg::*;
;
  logic clock_in = 1'b0;
  logic reset_n_in = 1'b0;
  host_req_type host_req;
  logic [7:0] rdata;
  port_ctrl_type ctrl = '0;
  status_event_type events;
  logic line_rd, modem_rd;
  logic ls_set = 1'b0;
  logic modem_chg = 1'b0;
  logic bit_tick = 1'b0;
  logic char_tick = 1'b0;
  logic rx_line = 1'b1;
  logic tx_line, irq, irq_oe, rx_ready, tx_idle;
  logic [1:0] tick_cnt = 2'h0;
  logic [5:0] char_cnt = 6'h00;
  int num_errors = 0;
  int check_count = 0;

  // 200 MHz clock
  always #2.5 clock_in = ~clock_in;
  // bit tick every 4 clocks, character tick every 40
  always @(negedge clock_in)
  begin
    tick_cnt <= tick_cnt + 2'h1;
    bit_tick <= (tick_cnt == 2'h3);
    char_cnt <= (char_cnt == 6'h27) ? 6'h00 : char_cnt + 6'h01;
    char_tick <= (char_cnt == 6'h27);
  end
  assign events = '{line_status_set: ls_set, line_status_read: line_rd,
                    modem_change: modem_chg, modem_status_read: modem_rd};

  uart_buffers #(.FIFO_DEPTH(8)) i_dut (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .host_in(host_req), .rdata_out(rdata),
    .ctrl_in(ctrl), .events_in(events), .bit_tick_in(bit_tick), .char_tick_in(char_tick),
    .rx_serial_in(rx_line), .tx_serial_out(tx_line), .irq_out(irq), .irq_oe_out(irq_oe),
    .rx_data_ready_out(rx_ready), .tx_idle_out(tx_idle)
  );
  host_model i_host (
    .clock_in(clock_in), .host_out(host_req), .rdata_in(rdata),
    .line_read_out(line_rd), .modem_read_out(modem_rd)
  );

  // compare and count
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // register read compared with an expected byte
  task automatic rd_chk(input logic [2:0] addr, input logic [7:0] exp, input string what);
    logic [7:0] d;
    i_host.reg_read(addr, 0, d);
    check(d, exp, what);
  endtask : rd_chk

  // serial frame into the receiver: start, 8 data lsb first, stop
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      do @(negedge clock_in); while (tick_cnt != 2'h1);
      rx_line = frame[i];
    end
    repeat (8) @(negedge clock_in);
  endtask : send_byte

  // capture one frame from the transmitter, sampling mid-bit
  task automatic tx_capture(output logic [7:0] b);
    int n;
    n = 0;
    while (tx_line !== 1'b0 && n < 200)
    begin
      @(negedge clock_in);
      n++;
    end
    check({7'h0, tx_line}, 8'h00, "tx start bit");
    repeat (2) @(negedge clock_in);
    for (int i = 0; i < 8; i++)
    begin
      repeat (4) @(negedge clock_in);
      b[i] = tx_line;
    end
    repeat (4) @(negedge clock_in);
    check({7'h0, tx_line}, 8'h01, "tx stop bit");
  endtask : tx_capture

  // one-cycle status event pulse
  task automatic pulse(input logic modem);
    @(negedge clock_in);
    if (modem)
      modem_chg = 1'b1;
    else
      ls_set = 1'b1;
    @(negedge clock_in);
    modem_chg = 1'b0;
    ls_set = 1'b0;
  endtask : pulse

  // reset values
  task automatic test_reset;
    rd_chk(OFS_IER, 8'h00, "enable after reset");
    rd_chk(OFS_IIR, 8'h01, "ident after reset");
    check({7'h0, irq}, 8'h00, "irq after reset");
    $display("test reset done");
  endtask : test_reset

  // enable register, reserved bits, divisor access remap, gate
  task automatic test_enable;
    i_host.reg_write(OFS_IER, 8'hff);
    rd_chk(OFS_IER, 8'h0f, "enable low nibble");
    check({7'h0, irq}, 8'h01, "irq holding empty");
    rd_chk(OFS_IIR, 8'h02, "holding empty id");
    rd_chk(OFS_IIR, 8'h01, "holding empty cleared by read");
    @(negedge clock_in);
    ctrl.irq_output_gate = 1'b1;
    #1 check({7'h0, irq_oe}, 8'h01, "gate on");
    @(negedge clock_in);
    ctrl.divisor_latch_access = 1'b1;
    i_host.reg_write(OFS_IER, 8'h00);
    rd_chk(OFS_IER, 8'h00, "enable hidden by divisor access");
    rd_chk(OFS_IIR, 8'h01, "ident with divisor access");
    @(negedge clock_in);
    ctrl.divisor_latch_access = 1'b0;
    ctrl.irq_output_gate = 1'b0;
    #1 check({7'h0, irq_oe}, 8'h00, "gate off");
    rd_chk(OFS_IER, 8'h0f, "write under divisor access ignored");
    rd_chk(3'h3, 8'h00, "unmapped offset");
    i_host.reg_write(OFS_IER, 8'h00);
    $display("test enable done");
  endtask : test_enable

  // two bytes back to back through holding and shifter
  task automatic test_tx;
    logic [7:0] a, b;
    i_host.reg_write(OFS_IER, 8'h02);
    fork
      begin
        tx_capture(a);
        tx_capture(b);
      end
      begin
        i_host.reg_write(OFS_DATA, 8'h1d);
        i_host.reg_write(OFS_DATA, 8'hc6);
      end
    join
    check(a, 8'h1d, "first tx byte");
    check(b, 8'hc6, "second tx byte");
    repeat (4) @(negedge clock_in);
    check({7'h0, tx_idle}, 8'h01, "tx idle");
    rd_chk(OFS_IIR, 8'h02, "holding empty after tx");
    i_host.reg_write(OFS_IER, 8'h00);
    $display("test tx done");
  endtask : test_tx

  // single-character receive outside fifo mode
  task automatic test_rx;
    i_host.reg_write(OFS_IER, 8'h01);
    send_byte(8'h1d);
    rd_chk(OFS_IIR, 8'h04, "data available id");
    check({7'h0, irq}, 8'h01, "irq data");
    rd_chk(OFS_DATA, 8'h1d, "received byte");
    rd_chk(OFS_IIR, 8'h01, "data cleared by read");
    i_host.reg_write(OFS_IER, 8'h00);
    send_byte(8'h62);
    rd_chk(OFS_IIR, 8'h01, "no enables no id");
    check({7'h0, irq}, 8'h00, "no enables no irq");
    check({7'h0, rx_ready}, 8'h01, "data ready still tracked");
    rd_chk(OFS_DATA, 8'h62, "second byte");
    $display("test rx done");
  endtask : test_rx

  // all four sources pending, served in priority order
  task automatic test_priority;
    i_host.reg_write(OFS_DATA, 8'h55);
    pulse(1'b1);
    pulse(1'b0);
    send_byte(8'h9e);
    i_host.reg_write(OFS_IER, 8'h0f);
    rd_chk(OFS_IIR, 8'h06, "line status first");
    i_host.status_read(1'b0);
    rd_chk(OFS_IIR, 8'h04, "data second");
    rd_chk(OFS_DATA, 8'h9e, "priority byte");
    rd_chk(OFS_IIR, 8'h02, "holding empty third");
    rd_chk(OFS_IIR, 8'h00, "modem last");
    check({7'h0, irq}, 8'h01, "irq modem");
    i_host.status_read(1'b1);
    rd_chk(OFS_IIR, 8'h01, "modem cleared");
    check({7'h0, irq}, 8'h00, "irq removed");
    i_host.reg_write(OFS_IER, 8'h00);
    $display("test priority done");
  endtask : test_priority

  // report frozen while an identification read is held
  task automatic test_freeze;
    logic [7:0] d;
    i_host.reg_write(OFS_IER, 8'h04);
    fork
      i_host.reg_read(OFS_IIR, 6, d);
      begin
        repeat (3) @(negedge clock_in);
        pulse(1'b0);
      end
    join
    check(d, 8'h01, "frozen report");
    rd_chk(OFS_IIR, 8'h06, "report after access");
    i_host.status_read(1'b0);
    rd_chk(OFS_IIR, 8'h01, "line status cleared");
    i_host.reg_write(OFS_IER, 8'h00);
    $display("test freeze done");
  endtask : test_freeze

  // fifo mode: trigger levels, fill to refusal, time-out
  task automatic test_fifo;
    int lvl [4] = '{1, 4, 8, 8};
    i_host.reg_write(OFS_IER, 8'h01);
    @(negedge clock_in);
    ctrl.fifo_enable = 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      @(negedge clock_in);
      ctrl.rx_trigger = c[1:0];
      for (int i = 0; i < lvl[c] - 1; i++) send_byte(8'h40 + 8'(i));
      rd_chk(OFS_IIR, 8'hc1, "below trigger");
      send_byte(8'h40 + 8'(lvl[c] - 1));
      if (c == 3) send_byte(8'h48);
      rd_chk(OFS_IIR, 8'hc4, "at trigger");
      for (int i = 0; i < lvl[c] + (c == 3); i++)
        rd_chk(OFS_DATA, 8'h40 + 8'(i), "fifo byte");
      check({7'h0, rx_ready}, 8'h00, "fifo drained");
    end
    @(negedge clock_in);
    ctrl.rx_trigger = 2'h1;
    send_byte(8'h2b);
    rd_chk(OFS_IIR, 8'hc1, "no early time-out");
    repeat (240) @(negedge clock_in);
    rd_chk(OFS_IIR, 8'hcc, "time-out id");
    rd_chk(OFS_DATA, 8'h2b, "time-out byte");
    rd_chk(OFS_IIR, 8'hc1, "time-out cleared");
    @(negedge clock_in);
    ctrl.fifo_enable = 1'b0;
    rd_chk(OFS_IIR, 8'h01, "fifo bits off");
    $display("test fifo done");
  endtask : test_fifo

  // verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run

  // main sequence
  initial
  begin
    repeat (3) @(posedge clock_in);
    @(negedge clock_in);
    reset_n_in = 1'b1;
    ctrl.irq_output_gate = 1'b1;
    test_reset();
    test_enable();
    test_tx();
    test_rx();
    test_priority();
    test_freeze();
    test_fifo();
    complete_run();
  end

  // watchdog, well beyond the expected few thousand cycles
  initial
  begin
    #100000;
    num_errors++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule : uart_buffers_tb
